// [rtl/dalm_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RULE1] two independent alarms, own thresholds and counts
// [RULE2] four-bit source select per alarm, zero disables
// [RULE3] per-alarm bit picks rate-of-change or static
// [RULE4] bit four picks filtered or unfiltered data
// [RULE5] pitch and roll always use filtered data
// [RULE6] bit two enables the indicator output
// [RULE7] bit one sets indicator active level
// [RULE8] bit zero routes indicator to line two
// [RULE9] threshold bit 15 picks above or below
// [RULE10] threshold bits 13..0 hold compare value
// [RULE11] sample count low byte, zero counts one
// [RULE12] window equals count times sample period
// [RULE13] host writes control then thresholds, bytewise
// [RULE14] alarm states shown at status bits 8, 9
// [RULE15] status read clears, persisting alarms reassert
// [RULE16] compare delta over window once per sample
// [RULE17] drive active level while any alarm true
module dalm_monitor #(
  parameter int DW = 14
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // byte register port from the serial front end
  input  wire logic          regWrite,
  input  wire logic          regRead,
  input  wire logic [5:0]    regAddr,
  input  wire logic [7:0]    regWrData,
  output logic      [7:0]    regRdData_q,
  // sensor data, one word per source code, sampled on sampleTick
  input  wire logic          sampleTick,
  input  wire logic [DW*dalm_pkg::NSRC-1:0] rawData,
  input  wire logic [DW*dalm_pkg::NSRC-1:0] filtData,
  // general io lines (output enable low while driving)
  output logic               ioLineOne_q,
  output logic               ioLineOneOe_q,
  output logic               ioLineTwo_q,
  output logic               ioLineTwoOe_q
);
  logic [15:0] ctrl_q;
  logic [15:0] thr_q [2];
  logic [15:0] cnt_q [2];
  logic [1:0]  diag_q;
  logic [1:0]  cond;
  logic        anyAlarm;
  logic        drive;
  logic        tickSeen_q;
  logic        diagRd;

  // byte writes; reserved bits are stored but never used
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= dalm_pkg::RST_WORD;
      thr_q[0] <= dalm_pkg::RST_WORD;
      thr_q[1] <= dalm_pkg::RST_WORD;
      cnt_q[0] <= dalm_pkg::RST_WORD;
      cnt_q[1] <= dalm_pkg::RST_WORD;
    end else if (regWrite) begin
      unique case ({regAddr[5:1], 1'b0})
        dalm_pkg::ADDR_CTRL: begin
          if (regAddr[0]) ctrl_q[15:8] <= regWrData;
          else ctrl_q[7:0] <= regWrData;
        end
        dalm_pkg::ADDR_THR_ONE: begin
          if (regAddr[0]) thr_q[0][15:8] <= regWrData;
          else thr_q[0][7:0] <= regWrData;
        end
        dalm_pkg::ADDR_THR_TWO: begin
          if (regAddr[0]) thr_q[1][15:8] <= regWrData;
          else thr_q[1][7:0] <= regWrData;
        end
        dalm_pkg::ADDR_CNT_ONE: begin
          if (regAddr[0]) cnt_q[0][15:8] <= regWrData;
          else cnt_q[0][7:0] <= regWrData;
        end
        dalm_pkg::ADDR_CNT_TWO: begin
          if (regAddr[0]) cnt_q[1][15:8] <= regWrData;
          else cnt_q[1][7:0] <= regWrData;
        end
        default: ;
      endcase
    end
  end

  for (genvar ch = 0; ch < 2; ch++) begin : gCh // [RULE1]
    logic [3:0]    src;
    logic          useFilt;
    logic [DW-1:0] val;
    logic          srcOk;
    logic [3:0]    idx;
    assign src = ch ? ctrl_q[dalm_pkg::CTRL_SRC2_LSB +: 4]
                    : ctrl_q[dalm_pkg::CTRL_SRC1_LSB +: 4]; // [RULE2]
    assign srcOk = (src != dalm_pkg::SRC_OFF) && (src <= dalm_pkg::SRC_LAST);
    // incline sources have no unfiltered form here
    assign useFilt = ctrl_q[dalm_pkg::CTRL_FILT] // [RULE4]
                   || src == dalm_pkg::SRC_PITCH
                   || src == dalm_pkg::SRC_ROLL; // [RULE5]
    // codes past the last source would index beyond the data buses
    assign idx = srcOk ? src : dalm_pkg::SRC_OFF;
    assign val = useFilt ? filtData[DW*idx +: DW] : rawData[DW*idx +: DW];
    dalm_channel #(.DW(DW)) uChan (
      .mclk        (mclk),
      .rst         (rst),
      .sampleTick  (sampleTick),
      .sampleVal   (val),
      .srcValid    (srcOk),
      .rocMode     (ctrl_q[ch ? dalm_pkg::CTRL_ROC2
                                : dalm_pkg::CTRL_ROC1]), // [RULE3]
      .dirAbove    (thr_q[ch][dalm_pkg::THR_DIR]),
      .threshold   (thr_q[ch][dalm_pkg::THR_MSB:0]), // [RULE10]
      .sampleCount (cnt_q[ch][7:0]),
      .condition_q (cond[ch])
    );
  end

  assign diagRd = regRead && (regAddr == (dalm_pkg::ADDR_DIAG | 6'h01));

  // channel results settle one cycle after the tick, so flags load then
  always_ff @(posedge mclk) begin
    if (rst) begin
      tickSeen_q <= 1'b0;
    end else begin
      tickSeen_q <= sampleTick;
    end
  end

  // a read clears, but a condition loaded that same cycle still lands
  always_ff @(posedge mclk) begin
    if (rst) begin
      diag_q <= 2'h0;
    end else if (tickSeen_q) begin
      diag_q <= (diagRd ? 2'h0 : diag_q) | cond; // [RULE14]
    end else if (diagRd) begin
      diag_q <= 2'h0; // [RULE15]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdData_q <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        dalm_pkg::ADDR_CTRL:            regRdData_q <= ctrl_q[7:0];
        dalm_pkg::ADDR_CTRL | 6'h01:    regRdData_q <= ctrl_q[15:8];
        dalm_pkg::ADDR_THR_ONE:         regRdData_q <= thr_q[0][7:0];
        dalm_pkg::ADDR_THR_ONE | 6'h01: regRdData_q <= thr_q[0][15:8];
        dalm_pkg::ADDR_THR_TWO:         regRdData_q <= thr_q[1][7:0];
        dalm_pkg::ADDR_THR_TWO | 6'h01: regRdData_q <= thr_q[1][15:8];
        dalm_pkg::ADDR_CNT_ONE:         regRdData_q <= cnt_q[0][7:0];
        dalm_pkg::ADDR_CNT_ONE | 6'h01: regRdData_q <= cnt_q[0][15:8];
        dalm_pkg::ADDR_CNT_TWO:         regRdData_q <= cnt_q[1][7:0];
        dalm_pkg::ADDR_CNT_TWO | 6'h01: regRdData_q <= cnt_q[1][15:8];
        dalm_pkg::ADDR_DIAG | 6'h01:    regRdData_q <= {6'h00, diag_q};
        default:                        regRdData_q <= 8'h00;
      endcase
    end
  end

  assign anyAlarm = |cond; // [RULE17]
  assign drive = ctrl_q[dalm_pkg::CTRL_OUTEN]; // [RULE6]

  // a disabled indicator releases both lines
  always_ff @(posedge mclk) begin
    if (rst) begin
      ioLineOne_q   <= 1'b0;
      ioLineTwo_q   <= 1'b0;
      ioLineOneOe_q <= 1'b1;
      ioLineTwoOe_q <= 1'b1;
    end else begin
      ioLineOne_q <= anyAlarm ~^ ctrl_q[dalm_pkg::CTRL_POL]; // [RULE7]
      ioLineTwo_q <= anyAlarm ~^ ctrl_q[dalm_pkg::CTRL_POL];
      ioLineOneOe_q <= !(drive && !ctrl_q[dalm_pkg::CTRL_LINE]); // [RULE8]
      ioLineTwoOe_q <= !(drive && ctrl_q[dalm_pkg::CTRL_LINE]);
    end
  end

  AST_STATUS_FOLLOWS: assert property (@(posedge mclk) disable iff (rst)
    (tickSeen_q && !sampleTick) |=> (diag_q[0] >= cond[0])) // [RULE14]
    else $error("alarm one status missing");
  AST_STATUS_TWO: assert property (@(posedge mclk) disable iff (rst)
    (tickSeen_q && !sampleTick) |=> (diag_q[1] >= cond[1])) // [RULE14]
    else $error("alarm two status missing");
  AST_READ_CLEARS: assert property (@(posedge mclk) disable iff (rst)
    (regRead && !tickSeen_q && regAddr == (dalm_pkg::ADDR_DIAG | 6'h01))
    |=> diag_q == 2'h0) // [RULE15]
    else $error("status not cleared by read");
  AST_FLAGS_HOLD: assert property (@(posedge mclk) disable iff (rst)
    (!tickSeen_q && !diagRd) |=> diag_q == $past(diag_q)) // [RULE15]
    else $error("status changed without sample or read");
  AST_DISABLED_RELEASE: assert property (@(posedge mclk) disable iff (rst)
    !ctrl_q[dalm_pkg::CTRL_OUTEN] |=> ioLineOneOe_q && ioLineTwoOe_q) // [RULE6]
    else $error("line driven while disabled");
  AST_LEVEL: assert property (@(posedge mclk) disable iff (rst)
    $stable(ctrl_q) && $stable(cond) |=>
    ioLineTwo_q == ($past(anyAlarm) == $past(ctrl_q[dalm_pkg::CTRL_POL])))
    // [RULE7]
    else $error("indicator level wrong");
  AST_ROUTE: assert property (@(posedge mclk) disable iff (rst)
    (drive && $stable(ctrl_q)) |=>
    ioLineTwoOe_q == !$past(ctrl_q[dalm_pkg::CTRL_LINE])) // [RULE8]
    else $error("indicator routed to wrong line");
  AST_ROUTE_ONE: assert property (@(posedge mclk) disable iff (rst)
    drive |=> ioLineOneOe_q == $past(ctrl_q[dalm_pkg::CTRL_LINE])) // [RULE8]
    else $error("line one routing wrong");
  AST_SRC_OFF: assert property (@(posedge mclk) disable iff (rst)
    (sampleTick && ctrl_q[dalm_pkg::CTRL_SRC1_LSB +: 4] == dalm_pkg::SRC_OFF)
    |=> !cond[0]) // [RULE2]
    else $error("disabled alarm fired");
  AST_SRC_OFF_TWO: assert property (@(posedge mclk) disable iff (rst)
    (sampleTick && ctrl_q[dalm_pkg::CTRL_SRC2_LSB +: 4] == dalm_pkg::SRC_OFF)
    |=> !cond[1]) // [RULE2]
    else $error("disabled alarm two fired");
  AST_ONCE_PER_SAMPLE: assert property (@(posedge mclk) disable iff (rst)
    !sampleTick |=> $stable(cond)) // [RULE16]
    else $error("alarm changed between samples");
  AST_ANY_DRIVES: assert property (@(posedge mclk) disable iff (rst)
    (drive && !ctrl_q[dalm_pkg::CTRL_LINE] && $stable(ctrl_q)
     && $stable(cond) && anyAlarm)
    |=> !ioLineOneOe_q
        && ioLineOne_q == $past(ctrl_q[dalm_pkg::CTRL_POL])) // [RULE17]
    else $error("active alarm not shown");
endmodule
`default_nettype wire

// [rtl/dalm_pkg.sv]
package dalm_pkg;
  // register indices on the byte-wide port (even index = low byte)
  localparam logic [5:0] ADDR_THR_ONE = 6'h26;
  localparam logic [5:0] ADDR_THR_TWO = 6'h28;
  localparam logic [5:0] ADDR_CNT_ONE = 6'h2A;
  localparam logic [5:0] ADDR_CNT_TWO = 6'h2C;
  localparam logic [5:0] ADDR_CTRL    = 6'h2E;
  localparam logic [5:0] ADDR_DIAG    = 6'h3C;
  // control fields
  localparam int CTRL_SRC2_LSB = 12;
  localparam int CTRL_SRC1_LSB = 8;
  localparam int CTRL_ROC2     = 7;
  localparam int CTRL_ROC1     = 6;
  localparam int CTRL_FILT     = 4;
  localparam int CTRL_OUTEN    = 2;
  localparam int CTRL_POL      = 1;
  localparam int CTRL_LINE     = 0;
  // threshold fields
  localparam int THR_DIR       = 15;
  localparam int THR_MSB       = 13;
  // status bits
  localparam int DIAG_ALM1     = 8;
  localparam int DIAG_ALM2     = 9;
  // trigger sources
  localparam logic [3:0] SRC_OFF   = 4'h0;
  localparam logic [3:0] SRC_PITCH = 4'h9;
  localparam logic [3:0] SRC_ROLL  = 4'hA;
  localparam logic [3:0] SRC_LAST  = 4'hB;
  localparam int NSRC = 12;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0]  CNT_ONE  = 8'h01;
endpackage

// [rtl/dalm_channel.sv]
`timescale 1ns/1ps
`default_nettype none
// one alarm channel: static or rate-of-change compare, once per sample
module dalm_channel #(
  parameter int DW    = 14,
  parameter int DEPTH = 256
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // sample
  input  wire logic          sampleTick,
  input  wire logic [DW-1:0] sampleVal,
  input  wire logic          srcValid,
  // settings
  input  wire logic          rocMode,
  input  wire logic          dirAbove,
  input  wire logic [DW-1:0] threshold,
  input  wire logic [7:0]    sampleCount,
  // result
  output logic               condition_q
);
  logic [DW-1:0] histMem [DEPTH];
  logic [7:0]    wrPtr_q;
  logic [7:0]    lag;
  logic [DW-1:0] oldVal_q;
  logic [DW-1:0] cmpVal;
  logic          hit;

  // 0 and 1 both mean one sample back
  assign lag = (sampleCount == 8'h00) ? dalm_pkg::CNT_ONE : sampleCount; // [RULE11]
  // difference against the sample taken count samples earlier
  assign cmpVal = rocMode ? DW'(sampleVal - oldVal_q) : sampleVal; // [RULE16]
  assign hit = dirAbove ? ($signed(cmpVal) > $signed(threshold))
                        : ($signed(cmpVal) < $signed(threshold)); // [RULE9]

  // history is uninitialised storage; first window after reset is junk
  always_ff @(posedge mclk) begin
    if (sampleTick) begin
      histMem[wrPtr_q] <= sampleVal;
    end
  end

  // registered read port refetched every cycle; ticks need one idle
  // cycle between them so the newest write is seen
  always_ff @(posedge mclk) begin
    oldVal_q <= histMem[8'(wrPtr_q - lag)];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPtr_q <= 8'h00;
    end else if (sampleTick) begin
      wrPtr_q <= wrPtr_q + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      condition_q <= 1'b0;
    end else if (sampleTick) begin
      condition_q <= srcValid && hit; // [RULE12]
    end
  end
endmodule
`default_nettype wire

// [test/dalm_host.sv]
`timescale 1ns/1ps
`default_nettype none
// host on the byte register port; idle lines show inverted old values
module dalm_host (
  // clock
  input  wire logic       mclk,
  // byte register port
  output logic            regWrite,
  output logic            regRead,
  output logic [5:0]      regAddr,
  output logic [7:0]      regWrData,
  input  wire logic [7:0] regRdData_q
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 6'h00;
    regWrData = 8'h00;
  end
  task automatic wr8(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
  task automatic wr16(input logic [5:0] a, input logic [15:0] d);
    wr8(a + 6'h01, d[15:8]);
    wr8(a, d[7:0]);
  endtask
  task automatic rd8(input logic [5:0] a, output logic [7:0] d);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(negedge mclk);
    d = regRdData_q;
  endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic         mclk = 1'b0;
  logic         rst = 1'b1;
  logic         sampleTick = 1'b0;
  logic [167:0] rawData = '0;
  logic [167:0] filtData = '0;
  logic         regWrite;
  logic         regRead;
  logic [5:0]   regAddr;
  logic [7:0]   regWrData;
  logic [7:0]   regRdData_q;
  logic [7:0]   rd;
  logic         ioOne, oeOne, ioTwo, oeTwo;
  logic [15:0]  ctrl;
  int           n_mismatch = 0;
  int           checked = 0;
  int           rawV[12], filtV[12], src[2], rate_change_compare[2], dir[2], thr[2];
  int           cnt[2], expC[2], cntTab[4] = '{0, 1, 2, 6};
  int           hq[2][$];
  initial forever #25 mclk = ~mclk;
  dalm_host host_u (.mclk(mclk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData_q(regRdData_q));
  dalm_monitor #(.DW(14)) dut_u (.mclk(mclk), .rst(rst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData_q(regRdData_q),
    .sampleTick(sampleTick), .rawData(rawData), .filtData(filtData),
    .ioLineOne_q(ioOne), .ioLineOneOe_q(oeOne),
    .ioLineTwo_q(ioTwo), .ioLineTwoOe_q(oeTwo));
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string w, input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", w, e, s);
    end
  endtask
  // the history restarts at each new setup, so early windows are skipped
  task automatic model;
    int k, v, n;
    for (int c = 0; c < 2; c++) begin
      k = src[c];
      v = (k > 11) ? 0 : (ctrl[4] || k == 9 || k == 10) ? filtV[k] : rawV[k];
      hq[c].push_back(v);
      n = (cnt[c] == 0) ? 1 : cnt[c];
      if (k == 0 || k > 11) expC[c] = 0;
      else if (rate_change_compare[c] != 0 && hq[c].size() <= n) expC[c] = -1;
      else begin
        if (rate_change_compare[c] != 0) v = v - hq[c][hq[c].size() - 1 - n];
        expC[c] = (dir[c] != 0) ? int'(v > thr[c]) : int'(v < thr[c]);
      end
    end
  endtask
  task automatic tick;
    int any;
    @(posedge mclk);
    for (int k = 0; k < 12; k++) begin
      rawData[14*k +: 14] <= 14'(rawV[k]);
      filtData[14*k +: 14] <= 14'(filtV[k]);
    end
    sampleTick <= 1'b1;
    @(posedge mclk);
    sampleTick <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    model();
    host_u.rd8(dalm_pkg::ADDR_DIAG + 6'h01, rd);
    if (expC[0] >= 0 && expC[1] >= 0) begin
      any = expC[0] | expC[1];
      chk("status", rd, 8'(expC[1] * 2 + expC[0]));
      chk("oe one", 8'(oeOne), 8'(!(ctrl[2] && !ctrl[0])));
      chk("oe two", 8'(oeTwo), 8'(!(ctrl[2] && ctrl[0])));
      if (ctrl[2]) begin
        chk("line", 8'(ctrl[0] ? ioTwo : ioOne),
          8'(ctrl[1] ? any : !any));
      end
    end
    host_u.rd8(dalm_pkg::ADDR_DIAG + 6'h01, rd);
    chk("status cleared", rd, 8'h00);
  endtask
  initial begin
    repeat (90000) @(posedge mclk);
    n_mismatch++;
    close_out();
  end
  initial begin
    void'($urandom(32'hC6B9));
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    host_u.rd8(dalm_pkg::ADDR_CTRL + 6'h01, rd);
    chk("ctrl reset", rd, 8'h00);
    host_u.rd8(6'h10, rd);
    chk("unmapped", rd, 8'h00);
    chk("oe reset", 8'(oeOne & oeTwo), 8'h01);
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      src[0] = i % 16;
      src[1] = (i + 5) % 16;
      ctrl = 16'($urandom);
      ctrl[15:8] = {4'(src[1]), 4'(src[0])};
      for (int c = 0; c < 2; c++) begin
        rate_change_compare[c] = (i >> c) % 2;
        ctrl[6 + c] = 1'(rate_change_compare[c]);
      end
      // control goes first, then thresholds and counts
      host_u.wr16(dalm_pkg::ADDR_CTRL, ctrl);
      for (int c = 0; c < 2; c++) begin
        dir[c] = $urandom % 2;
        thr[c] = int'($urandom % 6001) - 3000;
        cnt[c] = cntTab[(i + c) % 4];
        host_u.wr16(c ? dalm_pkg::ADDR_THR_TWO : dalm_pkg::ADDR_THR_ONE,
          {1'(dir[c]), 1'($urandom), 14'(thr[c])});
        host_u.wr16(c ? dalm_pkg::ADDR_CNT_TWO : dalm_pkg::ADDR_CNT_ONE,
          {8'($urandom), 8'(cnt[c])});
        hq[c].delete();
      end
      host_u.rd8(dalm_pkg::ADDR_CTRL + 6'h01, rd);
      chk("ctrl readback", rd, ctrl[15:8]);
      repeat (8) begin
        for (int k = 0; k < 12; k++) begin
          rawV[k] = int'($urandom % 8001) - 4000;
          filtV[k] = int'($urandom % 8001) - 4000;
        end
        tick();
      end
    end
    $display("test alarms done");
    close_out();
  end
endmodule
`default_nettype wire
